// [rtl/flash_read_pkg.sv]
// shared constants, states and opcode decoding for the serial flash read link
`default_nettype none
package flash_read_pkg;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_READ4 = 8'h13;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_FAST4 = 8'h0C;
  localparam logic [7:0] OP_DUAL = 8'h3B;
  localparam logic [7:0] OP_DUAL4 = 8'h3C;
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] ADDR3_BITS = 6'h18;
  localparam logic [5:0] ADDR4_BITS = 6'h20;
  localparam logic [5:0] SINGLE_RISES = 6'h08;
  localparam logic [5:0] DUAL_RISES = 6'h04;
  localparam logic [2:0] SINGLE_LAST = 3'h7;
  localparam logic [2:0] DUAL_LAST = 3'h3;
  localparam int LAT_W = 4;
  localparam int CLK_PERIOD_NS = 100;
  localparam int SCK_HALF_NS = 800;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] SCK_HALF_LAST = 4'(SCK_HALF_CYC - 1);

  typedef enum logic [2:0] {
    DEV_IDLE = 3'h0,
    DEV_CMD = 3'h1,
    DEV_ADDR = 3'h3,
    DEV_DUMMY = 3'h2,
    DEV_DATA = 3'h6,
    DEV_SKIP = 3'h4
  } dev_state_e;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_CMD = 3'h1,
    H_ADDR = 3'h3,
    H_DUMMY = 3'h2,
    H_DATA = 3'h6,
    H_END = 3'h7
  } host_state_e;

  function automatic logic op_known_f(input logic [7:0] op);
    op_known_f = (op == OP_READ) || (op == OP_READ4) || (op == OP_FAST) ||
      (op == OP_FAST4) || (op == OP_DUAL) || (op == OP_DUAL4);
  endfunction

  function automatic logic [5:0] addr_bits_f(input logic [7:0] op, input logic alb);
    if ((op == OP_READ4) || (op == OP_FAST4) || (op == OP_DUAL4))
      addr_bits_f = ADDR4_BITS;
    else if (alb)
      addr_bits_f = ADDR4_BITS;
    else
      addr_bits_f = ADDR3_BITS;
  endfunction

  function automatic logic has_latency_f(input logic [7:0] op);
    has_latency_f = (op != OP_READ) && (op != OP_READ4);
  endfunction

  function automatic logic is_dual_f(input logic [7:0] op);
    is_dual_f = (op == OP_DUAL) || (op == OP_DUAL4);
  endfunction
endpackage
`default_nettype wire

// [rtl/flash_link_if.sv]
// serial flash link between the memory controller end and the memory end
`timescale 1ns/10ps
`default_nettype none
interface flash_link_if;
  logic sck;
  logic cs_n;
  logic [1:0] host_io_o;
  logic [1:0] host_io_oe;
  logic [1:0] dev_io_o;
  logic [1:0] dev_io_oe;
  wire [1:0] io;

  // line 0 is serial_in_line0, line 1 is serial_out_line1; undriven lines pull high
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_line
      assign io[g] = dev_io_oe[g] ? dev_io_o[g] : (host_io_oe[g] ? host_io_o[g] : 1'b1);
    end
  endgenerate

  modport host (output sck, output cs_n, output host_io_o, output host_io_oe, input io);
  modport dev (input sck, input cs_n, input io, output dev_io_o, output dev_io_oe);
endinterface
`default_nettype wire

// [rtl/flash_read_dev.sv]
// memory end: decodes single, fast and dual output array reads and returns data
`timescale 1ns/10ps
`default_nettype none
module flash_read_dev #(
  parameter int ADDR_W = 24,
  parameter int MEM_AW = 8
) (
  input wire logic clk, // 10 MHz system clock
  input wire logic rst_b, // asynchronous reset, active low
  flash_link_if.dev link, // serial link to the controller
  input wire logic address_length_bit, // 1: plain opcodes take four address bytes
  input wire logic [flash_read_pkg::LAT_W-1:0] latency_code_field, // latency cycles
  input wire logic mem_we, // array load strobe
  input wire logic [MEM_AW-1:0] mem_waddr, // array load index
  input wire logic [7:0] mem_wdata, // array load byte
  output logic read_active // data return phase in progress
);
  import flash_read_pkg::*;

  logic [3:0] meta_ff;
  logic [3:0] sync_ff;
  logic sck_prev_ff;
  dev_state_e state_ff;
  dev_state_e nxt_state;
  logic [31:0] sr_ff;
  logic [31:0] nxt_sr;
  logic [5:0] cnt_ff;
  logic [5:0] nxt_cnt;
  logic [7:0] op_ff;
  logic [7:0] nxt_op;
  logic [ADDR_W-1:0] addr_ff;
  logic [ADDR_W-1:0] nxt_addr;
  logic [LAT_W-1:0] dummy_ff;
  logic [LAT_W-1:0] nxt_dummy;
  logic [7:0] dsr_ff;
  logic [7:0] nxt_dsr;
  logic [2:0] dcnt_ff;
  logic [2:0] nxt_dcnt;
  logic [1:0] io_o_ff;
  logic [1:0] nxt_io_o;
  logic [1:0] io_oe_ff;
  logic [1:0] nxt_io_oe;
  logic read_active_ff;
  logic [7:0] mem_ff [2**MEM_AW];

  // pins cross into clk through two flops before anything looks at them
  wire sck_s = sync_ff[3];
  wire cs_n_s = sync_ff[2];
  wire io0_s = sync_ff[0];
  wire sck_rise = sck_s & ~sck_prev_ff;
  wire sck_fall = ~sck_s & sck_prev_ff;
  wire [31:0] shift_in = {sr_ff[30:0], io0_s};
  wire [5:0] addr_bits = addr_bits_f(op_ff, address_length_bit);
  wire dual = is_dual_f(op_ff);
  wire [7:0] rd_byte = mem_ff[addr_ff[MEM_AW-1:0]];
  wire dummy_done = (state_ff == DEV_DUMMY) && (dummy_ff == '0);
  wire emit = sck_fall && ((state_ff == DEV_DATA) || dummy_done);
  wire load = emit && (dummy_done || (dcnt_ff == 3'h0));
  wire [7:0] src = load ? rd_byte : dsr_ff;

  assign link.dev_io_o = io_o_ff;
  assign link.dev_io_oe = io_oe_ff;
  assign read_active = read_active_ff;

  always_comb
  begin
    nxt_state = state_ff;
    nxt_sr = sr_ff;
    nxt_cnt = cnt_ff;
    nxt_op = op_ff;
    nxt_addr = addr_ff;
    nxt_dummy = dummy_ff;
    nxt_dsr = dsr_ff;
    nxt_dcnt = dcnt_ff;
    nxt_io_o = io_o_ff;
    nxt_io_oe = io_oe_ff;
    if (cs_n_s)
    begin
      // select high ends the command at once, whatever phase it is in
      nxt_state = DEV_IDLE;
      nxt_cnt = 6'h00;
      nxt_io_oe = 2'h0;
    end
    else
    begin
      unique case (state_ff)
        DEV_IDLE:
        begin
          nxt_state = DEV_CMD;
          nxt_cnt = 6'h00;
        end
        DEV_CMD:
          if (sck_rise)
          begin
            nxt_sr = shift_in;
            nxt_cnt = cnt_ff + 6'h01;
            if (cnt_ff == CMD_BITS - 6'h01)
            begin
              nxt_op = shift_in[7:0];
              nxt_cnt = 6'h00;
              // double-rate opcodes are not decoded here, so they are skipped
              nxt_state = op_known_f(shift_in[7:0]) ? DEV_ADDR : DEV_SKIP;
            end
          end
        DEV_ADDR:
          if (sck_rise)
          begin
            nxt_sr = shift_in;
            nxt_cnt = cnt_ff + 6'h01;
            if (cnt_ff == addr_bits - 6'h01)
            begin
              // a four-byte address keeps only its low ADDR_W bits
              nxt_addr = shift_in[ADDR_W-1:0];
              // these reads carry no mode bits
              nxt_dummy = has_latency_f(op_ff) ? latency_code_field : '0;
              nxt_state = DEV_DUMMY;
            end
          end
        DEV_DUMMY:
          // line values are never sampled here; only falling edges count
          if (sck_fall)
          begin
            if (dummy_done)
              nxt_state = DEV_DATA;
            else
              nxt_dummy = dummy_ff - 4'h1;
          end
        DEV_DATA:
          nxt_state = DEV_DATA;
        DEV_SKIP:
          nxt_state = DEV_SKIP;
        default:
          nxt_state = DEV_IDLE;
      endcase
      if (emit)
      begin
        // no learning pattern: it belongs to double-rate reads, none decoded
        if (dual)
        begin
          nxt_io_o = src[7:6];
          nxt_io_oe = 2'h3;
          nxt_dsr = {src[5:0], 2'h0};
        end
        else
        begin
          nxt_io_o = {src[7], 1'b0};
          nxt_io_oe = 2'h2;
          nxt_dsr = {src[6:0], 1'b0};
        end
        if (load)
        begin
          nxt_addr = addr_ff + 1'b1;
          nxt_dcnt = dual ? DUAL_LAST : SINGLE_LAST;
        end
        else
          nxt_dcnt = dcnt_ff - 3'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_ff <= 4'h4;
      sync_ff <= 4'h4;
      sck_prev_ff <= 1'b0;
    end
    else
    begin
      meta_ff <= {link.sck, link.cs_n, link.io};
      sync_ff <= meta_ff;
      sck_prev_ff <= sck_s;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff <= DEV_IDLE;
      sr_ff <= 32'h0;
      cnt_ff <= 6'h00;
      op_ff <= 8'h00;
      addr_ff <= '0;
      dummy_ff <= '0;
    end
    else
    begin
      state_ff <= nxt_state;
      sr_ff <= nxt_sr;
      cnt_ff <= nxt_cnt;
      op_ff <= nxt_op;
      addr_ff <= nxt_addr;
      dummy_ff <= nxt_dummy;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      dsr_ff <= 8'h00;
      dcnt_ff <= 3'h0;
      io_o_ff <= 2'h0;
      io_oe_ff <= 2'h0;
      read_active_ff <= 1'b0;
    end
    else
    begin
      dsr_ff <= nxt_dsr;
      dcnt_ff <= nxt_dcnt;
      io_o_ff <= nxt_io_o;
      io_oe_ff <= nxt_io_oe;
      read_active_ff <= (nxt_state == DEV_DATA);
    end
  end

  // array image is loaded from the user side; it has no reset to save area
  always_ff @(posedge clk)
  begin
    if (mem_we)
      mem_ff[mem_waddr] <= mem_wdata;
  end
endmodule
`default_nettype wire

// [rtl/flash_read_host.sv]
// controller end: issues one array read and queues the returned bytes in a fifo
`timescale 1ns/10ps
`default_nettype none
module flash_rx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk, // system clock
  input wire logic rst_b, // asynchronous reset, active low
  input wire logic wr_valid, // write offer
  output logic wr_ready, // room for a word
  input wire logic [WIDTH-1:0] wr_data, // written word
  output logic rd_valid, // word available
  input wire logic rd_ready, // reader takes the word
  output logic [WIDTH-1:0] rd_data // oldest word
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);
  localparam logic [AW:0] CNT_FULL = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [AW:0] cnt_ff;

  wire push = wr_valid && wr_ready;
  wire pop = rd_valid && rd_ready;
  assign wr_ready = (cnt_ff != CNT_FULL);
  assign rd_valid = (cnt_ff != '0);
  assign rd_data = mem_ff[rp_ff];

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end
    else
    begin
      if (push)
        wp_ff <= (wp_ff == PTR_LAST) ? '0 : wp_ff + 1'b1;
      if (pop)
        rp_ff <= (rp_ff == PTR_LAST) ? '0 : rp_ff + 1'b1;
      cnt_ff <= cnt_ff + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end

  always_ff @(posedge clk)
  begin
    if (push)
      mem_ff[wp_ff] <= wr_data;
  end
endmodule

module flash_read_host #(
  parameter int FIFO_DEPTH = 8,
  parameter int LEN_W = 16
) (
  input wire logic clk, // 10 MHz system clock
  input wire logic rst_b, // asynchronous reset, active low
  flash_link_if.host link, // serial link to the memory
  input wire logic address_length_bit, // must match the memory's setting
  input wire logic [flash_read_pkg::LAT_W-1:0] latency_code, // must match the memory
  input wire logic start, // begin a read while idle
  input wire logic [7:0] opcode, // read instruction
  input wire logic [31:0] start_addr, // first byte address
  input wire logic [LEN_W-1:0] byte_count, // bytes to read, zero is ignored
  output logic busy, // read in progress
  output logic [7:0] rd_data, // returned byte
  output logic rd_valid, // byte available
  input wire logic rd_ready // user takes the byte
);
  import flash_read_pkg::*;

  host_state_e state_ff;
  logic [1:0] meta_ff;
  logic [1:0] io_s_ff;
  logic [3:0] div_ff;
  logic sck_ff;
  logic cs_n_ff;
  logic oe0_ff;
  logic [39:0] tx_ff;
  logic [5:0] cnt_ff;
  logic [7:0] op_ff;
  logic [7:0] rx_ff;
  logic [LEN_W-1:0] left_ff;
  logic busy_ff;
  logic fifo_ready;

  wire running = (state_ff != H_IDLE);
  // a full fifo freezes the link clock, which the memory tolerates
  wire stall = (state_ff == H_DATA) && !fifo_ready;
  wire tick = running && !stall && (div_ff == SCK_HALF_LAST);
  wire rise = tick && !sck_ff;
  wire fall = tick && sck_ff;
  wire dual = is_dual_f(op_ff);
  wire [5:0] in_abits = addr_bits_f(opcode, address_length_bit);
  wire [5:0] abits = addr_bits_f(op_ff, address_length_bit);
  wire [5:0] lat = has_latency_f(op_ff) ? {2'h0, latency_code} : 6'h00;
  wire [5:0] per_byte = dual ? DUAL_RISES : SINGLE_RISES;
  wire [7:0] rx_next = dual ? {rx_ff[5:0], io_s_ff[1], io_s_ff[0]} : {rx_ff[6:0], io_s_ff[1]};
  wire push = rise && (state_ff == H_DATA) && (cnt_ff == 6'h01);
  wire [39:0] tx_load = (in_abits == ADDR4_BITS) ? {opcode, start_addr} :
    {opcode, start_addr[23:0], 8'h00};

  assign link.sck = sck_ff;
  assign link.cs_n = cs_n_ff;
  assign link.host_io_o = {1'b0, tx_ff[39]};
  assign link.host_io_oe = {1'b0, oe0_ff};
  assign busy = busy_ff;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_ff <= 2'h3;
      io_s_ff <= 2'h3;
      div_ff <= 4'h0;
    end
    else
    begin
      meta_ff <= link.io;
      io_s_ff <= meta_ff;
      div_ff <= (!running || tick) ? 4'h0 : (stall ? div_ff : div_ff + 4'h1);
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff <= H_IDLE;
      sck_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      oe0_ff <= 1'b0;
      tx_ff <= 40'h0;
      cnt_ff <= 6'h00;
      op_ff <= 8'h00;
      rx_ff <= 8'h00;
      left_ff <= '0;
      busy_ff <= 1'b0;
    end
    else
    begin
      busy_ff <= running || (start && (byte_count != '0));
      if (tick)
        sck_ff <= !sck_ff;
      if (rise)
        cnt_ff <= cnt_ff - 6'h01;
      if (fall && ((state_ff == H_CMD) || (state_ff == H_ADDR)))
        tx_ff <= {tx_ff[38:0], 1'b0};
      if (fall && ((state_ff == H_DUMMY) || (state_ff == H_DATA)))
        oe0_ff <= 1'b0;
      unique case (state_ff)
        H_IDLE:
          if (start && (byte_count != '0))
          begin
            cs_n_ff <= 1'b0;
            oe0_ff <= 1'b1;
            tx_ff <= tx_load;
            op_ff <= opcode;
            cnt_ff <= CMD_BITS;
            left_ff <= byte_count;
            state_ff <= H_CMD;
          end
        H_CMD:
          if (rise && (cnt_ff == 6'h01))
          begin
            cnt_ff <= abits;
            state_ff <= H_ADDR;
          end
        H_ADDR:
          if (rise && (cnt_ff == 6'h01))
          begin
            cnt_ff <= (lat == 6'h00) ? per_byte : lat;
            state_ff <= (lat == 6'h00) ? H_DATA : H_DUMMY;
          end
        H_DUMMY:
          // select stays low through every latency cycle
          if (rise && (cnt_ff == 6'h01))
          begin
            cnt_ff <= per_byte;
            state_ff <= H_DATA;
          end
        H_DATA:
          if (rise)
          begin
            rx_ff <= rx_next;
            if (cnt_ff == 6'h01)
            begin
              cnt_ff <= per_byte;
              left_ff <= left_ff - 1'b1;
              if (left_ff == LEN_W'(1))
                state_ff <= H_END;
            end
          end
        H_END:
          if (fall)
          begin
            cs_n_ff <= 1'b1;
            state_ff <= H_IDLE;
          end
        default:
          state_ff <= H_IDLE;
      endcase
    end
  end

  flash_rx_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .rst_b(rst_b),
    .wr_valid(push),
    .wr_ready(fifo_ready),
    .wr_data(rx_next),
    .rd_valid(rd_valid),
    .rd_ready(rd_ready),
    .rd_data(rd_data)
  );
endmodule
`default_nettype wire

// [test/flash_link_sva.sv]
// concurrent checks on the serial flash link between controller and memory
`timescale 1ns/10ps
`default_nettype none
module flash_link_sva (
  input wire logic clk, // system clock
  input wire logic rst_b, // asynchronous reset, active low
  input wire logic sck, // link clock
  input wire logic cs_n, // chip select, active low
  input wire logic [1:0] host_io_o, // controller drive values
  input wire logic [1:0] host_io_oe, // controller enables
  input wire logic [1:0] dev_io_o, // memory drive values
  input wire logic [1:0] dev_io_oe, // memory enables
  input wire logic [1:0] io // resolved lines
);
  logic sck_ff;
  logic [5:0] rise_cnt_ff;
  logic [5:0] nxt_rise_cnt;
  wire sck_rise = sck & ~sck_ff;
  // saturates so a long data phase never wraps back into the address window
  assign nxt_rise_cnt = cs_n ? 6'h00 :
    rise_cnt_ff + {5'h00, sck_rise & (rise_cnt_ff != 6'h3F)};
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sck_ff <= 1'b0;
      rise_cnt_ff <= 6'h00;
    end
    else
    begin
      sck_ff <= sck;
      rise_cnt_ff <= nxt_rise_cnt;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  sequence frame_end_s;
    $rose(cs_n);
  endsequence
  sequence lines_quiet_s;
    ##[0:6] (dev_io_oe == 2'h0);
  endsequence
  property quiet_after_end_p;
    frame_end_s |-> lines_quiet_s;
  endproperty

  AST_NO_CONTENTION: assert property (dev_io_oe[0] |-> !host_io_oe[0])
    else $error("controller and memory drive line0 together");
  AST_HOST_LINE1_FREE: assert property (host_io_oe[1] == 1'b0)
    else $error("controller drives line1");
  AST_HOST_SHIFT_SCK_LOW: assert property (
    $changed(host_io_o[0]) && host_io_oe[0] |-> !sck)
    else $error("controller changed line0 while link clock high");
  AST_DEV_SHIFT_SCK_LOW: assert property (
    $changed(dev_io_o) && (dev_io_oe != 2'h0) && ($past(dev_io_oe) != 2'h0) |-> !sck)
    else $error("memory changed data while link clock high");
  AST_SCK_HIGH_HALF: assert property ($rose(sck) |-> sck [*8])
    else $error("link clock high phase too short");
  AST_SCK_LOW_HALF: assert property ($fell(sck) |-> !sck [*8])
    else $error("link clock low phase too short");
  AST_IDLE_SCK_LOW: assert property (cs_n |-> !sck)
    else $error("link clock high while deselected");
  AST_END_QUIET: assert property (quiet_after_end_p)
    else $error("memory still drives after deselect");
  // the count clears on deselect while the memory may still drive for a few cycles
  AST_NO_DRIVE_IN_ADDRESS: assert property (
    !cs_n && (rise_cnt_ff < 6'h20) |-> dev_io_oe == 2'h0)
    else $error("memory drove before the address was complete");
  AST_LINE1_PULLUP: assert property (!dev_io_oe[1] && !host_io_oe[1] |-> io[1])
    else $error("released line1 not pulled high");
endmodule
`default_nettype wire

// [test/serial_flash_array_read_test.sv]
// self-checking bench: controller end reads the memory end over the link
`timescale 1ns/10ps
`default_nettype none
module serial_flash_array_read_test;
  import flash_read_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic alb = 1'b0;
  logic [3:0] lat = 4'h0;
  logic mem_we = 1'b0;
  logic [7:0] mem_waddr = 8'h00;
  logic [7:0] mem_wdata = 8'h00;
  logic start = 1'b0;
  logic [7:0] opcode = 8'h00;
  logic [31:0] start_addr = 32'h0;
  logic [15:0] byte_count = 16'h0000;
  logic rd_ready = 1'b1;
  logic busy;
  logic read_active;
  logic [7:0] rd_data;
  logic rd_valid;
  int bad_count = 0;
  int checked = 0;

  always #(CLK_PERIOD_NS / 2) clk = ~clk;

  flash_link_if flash_link_if_inst ();
  flash_read_dev flash_read_dev_inst (.clk(clk), .rst_b(rst_b), .link(flash_link_if_inst.dev),
    .address_length_bit(alb), .latency_code_field(lat), .mem_we(mem_we),
    .mem_waddr(mem_waddr), .mem_wdata(mem_wdata), .read_active(read_active));
  flash_read_host flash_read_host_inst (.clk(clk), .rst_b(rst_b),
    .link(flash_link_if_inst.host), .address_length_bit(alb), .latency_code(lat),
    .start(start), .opcode(opcode), .start_addr(start_addr), .byte_count(byte_count),
    .busy(busy), .rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready));
  flash_link_sva flash_link_sva_inst (.clk(clk), .rst_b(rst_b), .sck(flash_link_if_inst.sck),
    .cs_n(flash_link_if_inst.cs_n), .host_io_o(flash_link_if_inst.host_io_o),
    .host_io_oe(flash_link_if_inst.host_io_oe), .dev_io_o(flash_link_if_inst.dev_io_o),
    .dev_io_oe(flash_link_if_inst.dev_io_oe), .io(flash_link_if_inst.io));

  function automatic logic [7:0] pat(input logic [7:0] i);
    pat = (i * 8'h1D) ^ 8'hA5;
  endfunction

  task automatic fail(input string msg);
    bad_count++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask

  task automatic results;
    if (bad_count == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic load_mem;
    for (int i = 0; i < 256; i++)
    begin
      @(posedge clk);
      mem_we <= 1'b1;
      mem_waddr <= 8'(i);
      mem_wdata <= pat(8'(i));
    end
    @(posedge clk);
    mem_we <= 1'b0;
  endtask

  // one complete read; silent means the memory must never answer
  task automatic run_read(input logic [7:0] op, input logic [31:0] addr, input logic a4,
                          input logic [3:0] lc, input int n, input logic stall,
                          input logic silent);
    int got;
    int cyc;
    logic seen_act;
    logic [7:0] exp;
    got = 0;
    seen_act = 1'b0;
    @(posedge clk);
    opcode <= op;
    start_addr <= addr;
    alb <= a4;
    lat <= lc;
    byte_count <= 16'(n);
    rd_ready <= ~stall;
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    for (cyc = 0; cyc < 20000 && (got < n || busy !== 1'b0 || cyc < 4); cyc++)
    begin
      @(posedge clk);
      // a stalled reader must find the fifo holding words, none lost
      if (stall && cyc == 2999 && rd_valid !== 1'b1)
        fail("fifo empty while reader stalled");
      if (stall && cyc == 3000)
        rd_ready <= 1'b1;
      if (read_active === 1'b1)
        seen_act = 1'b1;
      if (silent && flash_link_if_inst.dev_io_oe !== 2'h0)
        fail("memory answered an unknown opcode");
      if (rd_valid === 1'b1 && rd_ready === 1'b1)
      begin
        exp = silent ? 8'hFF : pat(8'(addr[7:0] + got));
        checked++;
        if (rd_data !== exp)
          fail("returned byte wrong");
        got++;
      end
    end
    // the memory sees select high only after its two-flop synchroniser
    repeat (4) @(posedge clk);
    checked++;
    if (got != n || busy !== 1'b0 || read_active !== 1'b0 || seen_act === silent)
      fail("read did not end cleanly");
    // one address step per byte, carried modulo the 24-bit array address
    if (!silent && flash_read_dev_inst.addr_ff !== 24'(addr + 32'(n)))
      fail("address counter did not step or wrap");
  endtask

  task automatic t_plain;
    run_read(OP_READ, 32'h0000_00F0, 1'b0, 4'h0, 4, 1'b0, 1'b0);
    run_read(OP_READ, 32'h0000_0033, 1'b0, 4'hF, 2, 1'b0, 1'b0);
  endtask

  task automatic t_wrap;
    run_read(OP_READ4, 32'hA5FF_FFFE, 1'b0, 4'h3, 4, 1'b0, 1'b0);
    run_read(OP_READ, 32'h00FF_FFFF, 1'b0, 4'h0, 3, 1'b0, 1'b0);
  endtask

  task automatic t_addr_len;
    run_read(OP_READ, 32'h1200_0040, 1'b1, 4'h0, 2, 1'b0, 1'b0);
    run_read(OP_FAST, 32'h3400_0081, 1'b1, 4'h2, 2, 1'b0, 1'b0);
  endtask

  task automatic t_latency;
    logic [3:0] codes [4] = '{4'h0, 4'h1, 4'h8, 4'hF};
    foreach (codes[i])
      run_read(OP_FAST, 32'h0000_0010 + 32'(i), 1'b0, codes[i], 3, 1'b0, 1'b0);
    run_read(OP_FAST4, 32'h0000_00C7, 1'b0, 4'h5, 2, 1'b0, 1'b0);
  endtask

  task automatic t_dual;
    run_read(OP_DUAL, 32'h0000_005A, 1'b0, 4'h2, 5, 1'b0, 1'b0);
    run_read(OP_DUAL4, 32'h7700_00FF, 1'b0, 4'h0, 3, 1'b0, 1'b0);
  endtask

  task automatic t_stall;
    run_read(OP_FAST, 32'h0000_0020, 1'b0, 4'h1, 12, 1'b1, 1'b0);
  endtask

  task automatic t_silent;
    run_read(8'h6B, 32'h0000_0000, 1'b0, 4'h1, 1, 1'b0, 1'b1);
  endtask

  initial
  begin
    repeat (60000) @(posedge clk);
    fail("watchdog expired");
    results();
  end

  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    load_mem();
    t_plain();
    t_wrap();
    t_addr_len();
    t_latency();
    t_dual();
    t_stall();
    t_silent();
    results();
  end
endmodule
`default_nettype wire
